// ==== rtl/cwa_pkg.sv ====
// package for the compare and word arithmetic datapath
// assumes a sequencer that decodes opcodes and fetches operands
//
// Overview of operation
// - every instruction clock is one period of the selected processor clock
// - ram, special-function or no-data operands use the primary cycle count
// - program memory operand costs 4 clocks unsegmented, 5 segmented
// - byte compare accumulator minus segmented pointer byte, flags only, 3 bytes
// - indexed compare x minus segmented pointer byte, flags only, 4 bytes
// - word add immediate into accumulator pair, carry and flags, 3 bytes, 1 clock
// - word add of accumulator pair to itself doubles it, 1 byte, 1 clock
// - word add segmented pointer word to accumulator pair, 4 bytes, 2 clocks
// - word subtract immediate, borrow into carry, 3 bytes, 1 clock
// - word subtract segmented absolute word with borrow into carry, 4 bytes
// - word compare segmented pointer word, pair unchanged, flags updated
// - unsigned multiply accumulator byte by x byte into pair, flags kept
package cwa_pkg;

    // ------------------------------------------------------------------
    // operations
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CWA_OP_CMP_BYTE   = 4'h0,
        CWA_OP_CMP_X      = 4'h1,
        CWA_OP_ADD_WORD_IMM   = 4'h2,
        CWA_OP_ADD_WORD_SELF  = 4'h3,
        CWA_OP_ADD_WORD_MEM   = 4'h4,
        CWA_OP_SUBTRACT_WORD_IMM   = 4'h5,
        CWA_OP_SUBTRACT_WORD_MEM   = 4'h6,
        CWA_OP_COMPARE_WORD_MEM   = 4'h7,
        CWA_OP_UNSIGNED_MULTIPLY       = 4'h8
    } cwa_op_t;

    // ------------------------------------------------------------------
    // operand region
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CWA_SRC_NONE = 2'h0,
        CWA_SRC_RAM  = 2'h1,
        CWA_SRC_PROG = 2'h2
    } cwa_src_t;

    // ------------------------------------------------------------------
    // request and result carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        cwa_op_t     op;
        cwa_src_t    src;
        logic [15:0] acc_pair;
        logic [7:0]  x_reg;
        logic [15:0] imm_word;
        logic [15:0] addr;
        logic [3:0]  upper_bank;
    } cwa_req_t;

    typedef struct packed {
        logic [15:0] acc_pair;
        logic        acc_we;
        logic        zero_flag;
        logic        half_carry_flag;
        logic        carry_flag;
        logic        flags_we;
        logic [2:0]  length;
        logic [2:0]  clocks;
    } cwa_res_t;

    // ------------------------------------------------------------------
    // cycle counts and lengths
    // ------------------------------------------------------------------
    localparam logic [2:0] CWA_CLK_PLAIN     = 3'h1;
    localparam logic [2:0] CWA_CLK_SEG       = 3'h2;
    localparam logic [2:0] CWA_CLK_PROG      = 3'h4;
    localparam logic [2:0] CWA_CLK_SEG_PROG  = 3'h5;
    localparam logic [2:0] CWA_LEN_1         = 3'h1;
    localparam logic [2:0] CWA_LEN_3         = 3'h3;
    localparam logic [2:0] CWA_LEN_4         = 3'h4;
    localparam int         CWA_BANK_W        = 4;
    localparam logic [2:0] CWA_STEP_RST      = 3'h0;

endpackage

// ==== rtl/cwa_addsub.sv ====
// 16-bit adder and subtracter with carry and half-carry
// assumes operands from the datapath on the same clock
`timescale 1ns/100ps
module cwa_addsub #(
    parameter int W = 16
) (
    // operands
    input  wire logic [W-1:0] i_a,
    input  wire logic [W-1:0] i_b,
    input  wire logic         i_sub,
    // result
    output logic      [W-1:0] o_sum,
    output logic              o_carry,
    output logic              o_half
);
    // half carry from bit 3 of the low byte
    wire logic [W:0]   full_w;
    wire logic [4:0]   nib_w;
    assign full_w  = i_sub ? ({1'b0, i_a} - {1'b0, i_b}) : ({1'b0, i_a} + {1'b0, i_b});
    assign nib_w   = i_sub ? ({1'b0, i_a[3:0]} - {1'b0, i_b[3:0]}) : ({1'b0, i_a[3:0]} + {1'b0, i_b[3:0]});
    assign o_sum   = full_w[W-1:0];
    assign o_carry = full_w[W];
    assign o_half  = nib_w[4];
endmodule

// ==== rtl/cwa_alu.sv ====
// compare, word arithmetic and multiply datapath
// assumes the sequencer holds the request stable while busy
`timescale 1ns/100ps
module cwa_alu (
    // clock and reset
    input  wire logic                i_sys_clk,
    input  wire logic                i_sys_rst,
    // request
    input  wire logic                i_valid,
    input  wire cwa_pkg::cwa_req_t   i_req,
    input  wire logic [15:0]         i_mem_data,
    // memory address
    output logic [19:0]              o_mem_addr,
    // result
    output logic                     o_busy,
    output logic                     o_done,
    output cwa_pkg::cwa_res_t        o_res
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CWA_ST_IDLE = 2'b01,
        CWA_ST_RUN  = 2'b10
    } cwa_state_t;

    cwa_state_t         state_r;
    cwa_state_t         state_nxt;
    logic [2:0]         step_r;
    cwa_pkg::cwa_res_t  res_r;
    logic [19:0]        addr_r;

    // ------------------------------------------------------------------
    // operand decode
    // ------------------------------------------------------------------
    wire logic          is_seg_w;
    wire logic          is_byte_w;
    wire logic          is_sub_w;
    wire logic          is_cmp_w;
    wire logic          is_mul_w;
    wire logic [15:0]   opa_w;
    wire logic [15:0]   opb_w;
    wire logic [15:0]   sum_w;
    wire logic          carry_w;
    wire logic          half_w;
    wire logic          zero_w;
    wire logic [15:0]   prod_w;
    wire logic [2:0]    clocks_w;
    wire logic [2:0]    len_w;
    wire logic [19:0]   addr_w;

    assign is_seg_w  = i_req.op inside {cwa_pkg::CWA_OP_CMP_BYTE, cwa_pkg::CWA_OP_CMP_X,
                                        cwa_pkg::CWA_OP_ADD_WORD_MEM, cwa_pkg::CWA_OP_SUBTRACT_WORD_MEM,
                                        cwa_pkg::CWA_OP_COMPARE_WORD_MEM};
    assign is_byte_w = (i_req.op == cwa_pkg::CWA_OP_CMP_BYTE) || (i_req.op == cwa_pkg::CWA_OP_CMP_X);
    assign is_cmp_w  = is_byte_w || (i_req.op == cwa_pkg::CWA_OP_COMPARE_WORD_MEM);
    assign is_sub_w  = is_cmp_w || (i_req.op == cwa_pkg::CWA_OP_SUBTRACT_WORD_IMM)
                       || (i_req.op == cwa_pkg::CWA_OP_SUBTRACT_WORD_MEM);
    assign is_mul_w  = (i_req.op == cwa_pkg::CWA_OP_UNSIGNED_MULTIPLY);

    assign addr_w    = {i_req.upper_bank, i_req.addr};

    assign opa_w = (i_req.op == cwa_pkg::CWA_OP_CMP_X)    ? {i_req.x_reg, 8'h00} :
                   (i_req.op == cwa_pkg::CWA_OP_CMP_BYTE) ? {i_req.acc_pair[15:8], 8'h00} :
                   i_req.acc_pair;
    assign opb_w = is_byte_w                                  ? {i_mem_data[7:0], 8'h00} :
                   (i_req.op == cwa_pkg::CWA_OP_ADD_WORD_SELF)    ? i_req.acc_pair :
                   (i_req.op == cwa_pkg::CWA_OP_ADD_WORD_IMM
                    || i_req.op == cwa_pkg::CWA_OP_SUBTRACT_WORD_IMM)  ? i_req.imm_word :
                   i_mem_data;

    cwa_addsub #(
        .W (16)
    ) u_addsub (
        .i_a     (is_byte_w ? {8'h00, opa_w[15:8]} : opa_w),
        .i_b     (is_byte_w ? {8'h00, opb_w[15:8]} : opb_w),
        .i_sub   (is_sub_w),
        .o_sum   (sum_w),
        .o_carry (carry_w),
        .o_half  (half_w)
    );

    // byte forms take carry from bit 8 of the 16-bit difference
    wire logic          flag_cy_w;
    assign flag_cy_w = is_byte_w ? sum_w[8] : carry_w;
    assign zero_w    = is_byte_w ? (sum_w[7:0] == 8'h00) : (sum_w == 16'h0000);

    assign prod_w = {8'h00, i_req.acc_pair[15:8]} * {8'h00, i_req.x_reg};

    assign clocks_w = (i_req.src == cwa_pkg::CWA_SRC_PROG)
                      ? (is_seg_w ? cwa_pkg::CWA_CLK_SEG_PROG : cwa_pkg::CWA_CLK_PROG)
                      : (is_seg_w ? cwa_pkg::CWA_CLK_SEG : cwa_pkg::CWA_CLK_PLAIN);

    assign len_w = (i_req.op == cwa_pkg::CWA_OP_ADD_WORD_SELF || is_mul_w) ? cwa_pkg::CWA_LEN_1 :
                   (i_req.op == cwa_pkg::CWA_OP_CMP_BYTE
                    || i_req.op == cwa_pkg::CWA_OP_ADD_WORD_IMM
                    || i_req.op == cwa_pkg::CWA_OP_SUBTRACT_WORD_IMM) ? cwa_pkg::CWA_LEN_3 :
                   cwa_pkg::CWA_LEN_4;

    // ------------------------------------------------------------------
    // result word
    // ------------------------------------------------------------------
    cwa_pkg::cwa_res_t  res_w;
    always_comb begin
        res_w                 = '0;
        res_w.length          = len_w;
        res_w.clocks          = clocks_w;
        res_w.acc_we          = !is_cmp_w;
        res_w.acc_pair        = is_mul_w ? prod_w : (is_cmp_w ? i_req.acc_pair : sum_w);
        res_w.flags_we        = !is_mul_w;
        res_w.zero_flag       = zero_w;
        res_w.half_carry_flag = half_w;
        res_w.carry_flag      = flag_cy_w;
    end

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    wire logic          start_w;
    wire logic          last_w;
    assign start_w = i_valid && (state_r == CWA_ST_IDLE);
    assign last_w  = (state_r == CWA_ST_RUN) && (step_r == 3'h1);

    always_comb begin
        case (state_r)
            CWA_ST_IDLE: state_nxt = (start_w && clocks_w != cwa_pkg::CWA_CLK_PLAIN) ? CWA_ST_RUN : CWA_ST_IDLE;
            CWA_ST_RUN:  state_nxt = last_w ? CWA_ST_IDLE : CWA_ST_RUN;
            default:     state_nxt = CWA_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r <= CWA_ST_IDLE;
            step_r  <= cwa_pkg::CWA_STEP_RST;
        end else begin
            state_r <= state_nxt;
            if (start_w)
                step_r <= 3'(clocks_w - 3'h1);
            else if (state_r == CWA_ST_RUN)
                step_r <= 3'(step_r - 3'h1);
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            res_r  <= '0;
            addr_r <= '0;
        end else if (start_w) begin
            res_r  <= res_w;
            addr_r <= addr_w;
        end
    end

    logic               done_r;
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            done_r <= 1'b0;
        else
            done_r <= (start_w && clocks_w == cwa_pkg::CWA_CLK_PLAIN) || last_w;
    end

    assign o_done     = done_r;
    assign o_busy     = (state_r == CWA_ST_RUN);
    assign o_res      = res_r;
    assign o_mem_addr = addr_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_prog_seg_five: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && is_seg_w && i_req.src == cwa_pkg::CWA_SRC_PROG |-> ##5 o_done)
        else $error("segmented program memory form not done in 5");

    a_ram_seg_two: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && is_seg_w && i_req.src != cwa_pkg::CWA_SRC_PROG |=> !o_done ##1 o_done)
        else $error("segmented ram form not done in 2");

    a_one_clock_done: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && clocks_w == 3'h1 |=> o_done && !o_busy)
        else $error("single clock form not done next cycle");

    a_cmp_keeps_pair: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && is_cmp_w |=> !o_res.acc_we && o_res.acc_pair == $past(i_req.acc_pair))
        else $error("compare altered the pair");

    a_mul_product: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && is_mul_w |=> o_res.acc_pair == ({8'h00, $past(i_req.acc_pair[15:8])} * {8'h00, $past(i_req.x_reg)})
                                && !o_res.flags_we)
        else $error("multiply product or flags wrong");

    a_self_double: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && i_req.op == cwa_pkg::CWA_OP_ADD_WORD_SELF
        |=> {o_res.carry_flag, o_res.acc_pair} == {$past(i_req.acc_pair), 1'b0})
        else $error("self add did not double");

    a_bank_address: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w |=> o_mem_addr[19:16] == $past(i_req.upper_bank))
        else $error("bank not above address");

    a_subtract_word_borrow: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && i_req.op == cwa_pkg::CWA_OP_SUBTRACT_WORD_IMM
        |=> o_res.carry_flag == ($past(i_req.acc_pair) < $past(i_req.imm_word)) && o_res.length == 3'h3)
        else $error("subtract borrow or length wrong");

    a_cmpx_zero: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && i_req.op == cwa_pkg::CWA_OP_CMP_X
        |=> o_res.zero_flag == ($past(i_req.x_reg) == $past(i_mem_data[7:0])) && o_res.length == 3'h4)
        else $error("indexed compare flags wrong");

    a_cmp_carry: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && i_req.op == cwa_pkg::CWA_OP_CMP_BYTE
        |=> o_res.carry_flag == ($past(i_req.acc_pair[15:8]) < $past(i_mem_data[7:0])))
        else $error("byte compare carry wrong");

    a_add_word_imm: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && i_req.op == cwa_pkg::CWA_OP_ADD_WORD_IMM
        |=> {o_res.carry_flag, o_res.acc_pair} == 17'($past(i_req.acc_pair) + 17'($past(i_req.imm_word))))
        else $error("immediate add sum wrong");

    a_add_word_mem: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && i_req.op == cwa_pkg::CWA_OP_ADD_WORD_MEM
        |=> o_res.acc_pair == 16'($past(i_req.acc_pair) + $past(i_mem_data)) && o_res.acc_we)
        else $error("memory add sum wrong");

    a_subtract_word_mem: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && i_req.op == cwa_pkg::CWA_OP_SUBTRACT_WORD_MEM
        |=> o_res.carry_flag == ($past(i_req.acc_pair) < $past(i_mem_data)))
        else $error("memory subtract borrow wrong");

    a_prog_plain_four: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && !is_seg_w && i_req.src == cwa_pkg::CWA_SRC_PROG |-> ##4 o_done)
        else $error("unsegmented program memory form not done in 4");

    a_prog_busy_span: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && is_seg_w && i_req.src == cwa_pkg::CWA_SRC_PROG |=> o_busy [*4] ##1 !o_busy)
        else $error("segmented program memory busy span wrong");

    a_ram_busy_one: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && is_seg_w && i_req.src != cwa_pkg::CWA_SRC_PROG |=> o_busy ##1 !o_busy)
        else $error("segmented ram busy span wrong");

    a_result_holds: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        !start_w |=> $stable(o_res) && $stable(o_mem_addr))
        else $error("result changed without a taken request");

    a_cmp_half: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && i_req.op == cwa_pkg::CWA_OP_CMP_BYTE
        |=> o_res.half_carry_flag == ($past(i_req.acc_pair[11:8]) < $past(i_mem_data[3:0])))
        else $error("byte compare half carry wrong");

    a_compare_word_flags: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && i_req.op == cwa_pkg::CWA_OP_COMPARE_WORD_MEM
        |=> o_res.carry_flag == ($past(i_req.acc_pair) < $past(i_mem_data))
            && o_res.zero_flag == ($past(i_req.acc_pair) == $past(i_mem_data)))
        else $error("word compare flags wrong");

    a_cmpx_carry: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && i_req.op == cwa_pkg::CWA_OP_CMP_X
        |=> o_res.carry_flag == ($past(i_req.x_reg) < $past(i_mem_data[7:0])) && !o_res.acc_we)
        else $error("indexed compare carry wrong");

    a_mem_lengths: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && i_req.op inside {cwa_pkg::CWA_OP_ADD_WORD_MEM, cwa_pkg::CWA_OP_SUBTRACT_WORD_MEM}
        |=> o_res.length == 3'h4 && o_res.acc_we)
        else $error("memory word form length wrong");

    a_mul_length: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        start_w && is_mul_w |=> o_res.length == 3'h1 && o_res.acc_we)
        else $error("multiply length wrong");

endmodule

// ==== tb/cwa_mem_model.sv ====
// memory model: one operand word for each 20-bit operand address
// assumes the address is held steady while a request waits
`timescale 1ns/100ps
module cwa_mem_model (
    // lookup
    input  wire logic [19:0] i_addr,
    input  wire logic        i_sel,
    // data
    output logic      [15:0] o_data
);
    // ------------------------------------------------------------------
    // word pattern
    // ------------------------------------------------------------------
    logic [15:0] word;
    assign word   = i_addr[15:0] ^ {i_addr[19:16], 12'h000};
    // unselected gives the inverse, never a stale match
    assign o_data = i_sel ? word : ~word;
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the compare and word arithmetic datapath
// assumes cwa_pkg is compiled first and the memory model sits beside it
`timescale 1ns/100ps
module tb_top;
    logic              i_sys_clk;
    logic              i_sys_rst;
    logic              i_valid;
    cwa_pkg::cwa_req_t i_req;
    logic [15:0]       i_mem_data;
    logic [19:0]       o_mem_addr;
    logic              o_busy;
    logic              o_done;
    cwa_pkg::cwa_res_t o_res;
    int                num_errors = 0;
    int                samples_checked = 0;

    cwa_alu i_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_valid(i_valid), .i_req(i_req),
                   .i_mem_data(i_mem_data), .o_mem_addr(o_mem_addr), .o_busy(o_busy), .o_done(o_done),
                   .o_res(o_res));
    cwa_mem_model i_mem (.i_addr({i_req.upper_bank, i_req.addr}), .i_sel(i_req.src != cwa_pkg::CWA_SRC_NONE),
                         .o_data(i_mem_data));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(string name, logic [19:0] seen, logic [19:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // operand word v is placed at the address that holds it
    function automatic cwa_pkg::cwa_req_t mk(logic [3:0] op, logic [1:0] src, logic [15:0] acc,
                                             logic [7:0] x, logic [15:0] v, logic [3:0] bank);
        cwa_pkg::cwa_req_t r;
        r.op         = cwa_pkg::cwa_op_t'(op);
        r.src        = cwa_pkg::cwa_src_t'(src);
        r.acc_pair   = acc;
        r.x_reg      = x;
        r.imm_word   = v;
        r.addr       = v ^ {bank, 12'h000};
        r.upper_bank = bank;
        return r;
    endfunction

    function automatic cwa_pkg::cwa_res_t expect_res(cwa_pkg::cwa_req_t r);
        cwa_pkg::cwa_res_t e;
        logic [15:0]       m;
        logic [16:0]       w;
        logic [8:0]        d;
        logic [7:0]        a;
        logic              sub;
        logic              prog;
        m          = r.addr ^ {r.upper_bank, 12'h000};
        prog       = (r.src == cwa_pkg::CWA_SRC_PROG);
        e          = '0;
        e.flags_we = 1'b1;
        e.length   = cwa_pkg::CWA_LEN_4;
        e.clocks   = prog ? cwa_pkg::CWA_CLK_SEG_PROG : cwa_pkg::CWA_CLK_SEG;
        sub        = 1'b1;
        case (r.op)
            cwa_pkg::CWA_OP_CMP_BYTE, cwa_pkg::CWA_OP_CMP_X: begin
                a = (r.op == cwa_pkg::CWA_OP_CMP_X) ? r.x_reg : r.acc_pair[15:8];
                d = {1'b0, a} - {1'b0, m[7:0]};
                e.zero_flag       = (d[7:0] == 8'h00);
                e.half_carry_flag = (a[3:0] < m[3:0]);
                e.carry_flag      = d[8];
                if (r.op == cwa_pkg::CWA_OP_CMP_BYTE) e.length = cwa_pkg::CWA_LEN_3;
                return e;
            end
            cwa_pkg::CWA_OP_ADD_WORD_MEM: sub = 1'b0;
            cwa_pkg::CWA_OP_SUBTRACT_WORD_MEM, cwa_pkg::CWA_OP_COMPARE_WORD_MEM: sub = 1'b1;
            default: begin
                e.clocks = prog ? cwa_pkg::CWA_CLK_PROG : cwa_pkg::CWA_CLK_PLAIN;
                e.length = cwa_pkg::CWA_LEN_3;
                m        = (r.op == cwa_pkg::CWA_OP_ADD_WORD_SELF) ? r.acc_pair : r.imm_word;
                sub      = (r.op == cwa_pkg::CWA_OP_SUBTRACT_WORD_IMM);
                if (r.op inside {cwa_pkg::CWA_OP_ADD_WORD_SELF, cwa_pkg::CWA_OP_UNSIGNED_MULTIPLY}) e.length = cwa_pkg::CWA_LEN_1;
                if (r.op == cwa_pkg::CWA_OP_UNSIGNED_MULTIPLY) begin
                    e.acc_pair = r.acc_pair[15:8] * r.x_reg;
                    e.acc_we   = 1'b1;
                    e.flags_we = 1'b0;
                    return e;
                end
            end
        endcase
        w = sub ? {1'b0, r.acc_pair} - {1'b0, m} : {1'b0, r.acc_pair} + {1'b0, m};
        e.acc_pair        = w[15:0];
        e.acc_we          = (r.op != cwa_pkg::CWA_OP_COMPARE_WORD_MEM);
        e.zero_flag       = (w[15:0] == 16'h0000);
        e.carry_flag      = w[16];
        e.half_carry_flag = sub ? (r.acc_pair[3:0] < m[3:0]) : ({1'b0, r.acc_pair[3:0]} + {1'b0, m[3:0]} > 5'h0f);
        return e;
    endfunction

    // called at a falling edge; junk disturbs the request while busy
    task automatic run_op(cwa_pkg::cwa_req_t r, bit junk = 1'b0);
        cwa_pkg::cwa_res_t e;
        int                n;
        bit                got;
        e       = expect_res(r);
        n       = int'(e.clocks);
        got     = 1'b0;
        i_req   = r;
        i_valid = 1'b1;
        @(posedge i_sys_clk);
        for (int k = 1; k <= 8 && !got; k++) begin
            @(negedge i_sys_clk);
            if (k == 1 && n > 1) i_valid = junk;
            if (k == 1 && junk) i_req.acc_pair = ~r.acc_pair;
            if (k == n - 1 && junk) i_valid = 1'b0;
            if (k < n) begin
                check("busy", o_busy, 1'b1);
                check("done_early", o_done, 1'b0);
            end else begin
                got = 1'b1;
                check("done", o_done, 1'b1);
                check("busy_end", o_busy, 1'b0);
                check("clocks", o_res.clocks, e.clocks);
                check("length", o_res.length, e.length);
                check("acc_we", o_res.acc_we, e.acc_we);
                check("flags_we", o_res.flags_we, e.flags_we);
                if (e.acc_we) check("acc_pair", o_res.acc_pair, e.acc_pair);
                if (e.flags_we) check("flags", {o_res.zero_flag, o_res.half_carry_flag, o_res.carry_flag},
                                      {e.zero_flag, e.half_carry_flag, e.carry_flag});
                if (r.src != cwa_pkg::CWA_SRC_NONE) check("mem_addr", o_mem_addr, {r.upper_bank, r.addr});
            end
        end
        if (!got) check("done_seen", 1'b0, 1'b1);
    endtask

    task automatic idle();
        i_valid = 1'b0;
        @(negedge i_sys_clk);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        check("rst_busy", o_busy, 1'b0);
        check("rst_done", o_done, 1'b0);
        check("rst_res", o_res[19:0], 20'h00000);
        i_sys_rst = 1'b0;
        @(negedge i_sys_clk);
    endtask

    // byte compare: half borrow, zero from program memory, full borrow
    task automatic t_cmp_byte();
        run_op(mk(4'h0, 2'h1, 16'h10aa, 8'h00, 16'h0001, 4'h3));
        run_op(mk(4'h0, 2'h2, 16'h05ff, 8'h00, 16'h0005, 4'hc));
        run_op(mk(4'h0, 2'h1, 16'h0000, 8'h00, 16'h00ff, 4'hf));
        idle();
    endtask

    task automatic t_cmp_x();
        run_op(mk(4'h1, 2'h2, 16'hffff, 8'h80, 16'h0081, 4'h1));
        run_op(mk(4'h1, 2'h1, 16'h0000, 8'h42, 16'h0042, 4'h7));
        idle();
    endtask

    task automatic t_add_word();
        run_op(mk(4'h2, 2'h0, 16'hffff, 8'h00, 16'h0001, 4'h0));
        run_op(mk(4'h3, 2'h0, 16'h8008, 8'h00, 16'h0000, 4'h0));
        run_op(mk(4'h4, 2'h1, 16'h0008, 8'h00, 16'h0008, 4'ha));
        run_op(mk(4'h4, 2'h2, 16'hf000, 8'h00, 16'h1000, 4'h6));
        run_op(mk(4'h2, 2'h2, 16'h00f0, 8'h00, 16'h0f10, 4'h0));
        idle();
    endtask

    task automatic t_subtract_word();
        run_op(mk(4'h5, 2'h0, 16'h0000, 8'h00, 16'h0001, 4'h0));
        run_op(mk(4'h6, 2'h2, 16'h1234, 8'h00, 16'h1234, 4'h9));
        run_op(mk(4'h6, 2'h1, 16'h0010, 8'h00, 16'h0001, 4'h2));
        idle();
    endtask

    // a second request while busy must be ignored
    task automatic t_compare_word();
        run_op(mk(4'h7, 2'h2, 16'h0100, 8'h00, 16'h0101, 4'h5), 1'b1);
        run_op(mk(4'h7, 2'h1, 16'h8000, 8'h00, 16'h8000, 4'he));
        idle();
    endtask

    task automatic t_unsigned_multiply();
        run_op(mk(4'h8, 2'h0, 16'hff00, 8'hff, 16'h0000, 4'h0));
        run_op(mk(4'h8, 2'h0, 16'h12aa, 8'h34, 16'h5555, 4'h0));
        idle();
    endtask

    // back-to-back requests with no gaps, one per clock except the 2-clock indexed compare
    task automatic t_back();
        run_op(mk(4'h2, 2'h0, 16'h1234, 8'h00, 16'h0ff0, 4'h0));
        run_op(mk(4'h5, 2'h0, 16'h1234, 8'h00, 16'h0235, 4'h0));
        run_op(mk(4'h8, 2'h0, 16'h0aff, 8'h0b, 16'h0000, 4'h0));
        run_op(mk(4'h1, 2'h1, 16'h0000, 8'h0f, 16'h0010, 4'hb));
        run_op(mk(4'h3, 2'h0, 16'h7fff, 8'h00, 16'h0000, 4'h0));
        idle();
    endtask

    // ------------------------------------------------------------------
    // clock, sequence, watchdog
    // ------------------------------------------------------------------
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    initial begin
        i_sys_rst = 1'b1;
        i_valid   = 1'b0;
        i_req     = '0;
        repeat (10) @(negedge i_sys_clk);
        t_reset();
        t_cmp_byte();
        t_cmp_x();
        t_add_word();
        t_subtract_word();
        t_compare_word();
        t_unsigned_multiply();
        t_back();
        tally_and_finish();
    end

    initial begin
        #20000;
        num_errors++;
        tally_and_finish();
    end
endmodule
